//--- cfg_loader_params.svh
/*
 Offsets, field positions, reset values and counts of the configuration word loader.
 Assumes it is included by bare name from design files that need these constants.
*/
`ifndef CFG_LOADER_PARAMS_SVH
`define CFG_LOADER_PARAMS_SVH

// Memory word addresses
`define WORD_FIRST 8'h54
`define WORD_STEP 8'h02
`define WORD_LAST_IDX 3'd7

// Word reset values, used when no memory is present
`define DEF_PM_WORD 16'h00FF
`define DEF_LL_WORD 16'h0004
`define DEF_P0_WORD 16'hFE02
`define DEF_P1_WORD 16'hFE12

// Configuration dword offsets
`define OFF_PMCAP 12'h040
`define OFF_PMDATA 12'h044
`define OFF_SLOTCAP 12'h0C0
`define OFF_PORTNUM 12'h0CC
`define OFF_SLOTCLK 12'h0D0
`define OFF_VCCNT 12'h144
`define OFF_TCMAP 12'h154
`define OFF_LLCTRL 12'h340

// Loader control and status
`define CTRL_ADDR 16'h4000
`define STAT_ADDR 16'h4004

// Field positions inside the dwords
`define NSR_BIT 3
`define PMDATA_LSB 24
`define AUX_LSB 22
`define D1_BIT 25
`define D2_BIT 26
`define PME_LSB 28
`define DSI_BIT 21
`define CLKCFG_BIT 28
`define LOW_PRIORITY_VC_COUNT_BIT 4
`define PNUM_LSB 24
`define TCMAP_LSB 1
`define SLOTI_BIT 24

// Cycles the present strap needs to pass its synchroniser
`define SETTLE_CYCLES 2'd3

`endif

//--- cfg_loader_pkg.sv
/*
 Types shared by the configuration word loader.
 Assumes nothing of its surroundings.
*/
package cfg_loader_pkg;
   typedef enum logic [2:0] {
      ST_WAIT = 3'b001,
      ST_FETCH = 3'b010,
      ST_DONE = 3'b100
   } load_state_e;

   typedef enum logic [1:0] {
      RESP_OKAY = 2'b00,
      RESP_SLVERR = 2'b10
   } axi_resp_e;
endpackage

//--- cfg_word_slot.sv
/*
 One 16-bit loaded word with its own reset value.
 Assumes load is a single-cycle strobe on the aclk domain.
*/
`timescale 1ns/1ps
module cfg_word_slot #(
   parameter logic [15:0] RESET_VAL = 16'h0000
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic load,
   input wire logic [15:0] load_data,
   output logic [15:0] word
);
   logic [15:0] word_r;
   logic [15:0] word_nxt;

   always_comb
   begin
      word_nxt = word_r;
      if (load)
      begin
         word_nxt = load_data;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         word_r <= RESET_VAL;
      end
      else
      begin
         word_r <= word_nxt;
      end
   end

   assign word = word_r;
endmodule

//--- ee_word_model.sv
/*
 Behavioural configuration memory word reader, answering one word per request.
 Assumes the loader holds ee_req and ee_addr until ee_ack; same clock as the loader.
*/
`timescale 1ns/1ps
module ee_word_model
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ee_req,
   input wire logic [7:0] ee_addr,
   input wire logic [3:0] ack_delay,
   input wire logic flip_data,
   output logic ee_ack,
   output logic [15:0] ee_rdata
);
   logic [3:0] wait_cnt;
   logic [15:0] base;

   assign base = {ee_addr ^ 8'h0F, ~ee_addr ^ 8'h22};

   // Data lines toggle outside an answer so no stale word is ever seen
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wait_cnt <= 4'h0;
         ee_ack <= 1'b0;
         ee_rdata <= 16'h0000;
      end
      else
      begin
         ee_ack <= 1'b0;
         ee_rdata <= ~ee_rdata;
         if (ee_req && !ee_ack)
         begin
            if (wait_cnt >= ack_delay)
            begin
               ee_ack <= 1'b1;
               ee_rdata <= flip_data ? ~base : base;
               wait_cnt <= 4'h0;
            end
            else
               wait_cnt <= wait_cnt + 4'h1;
         end
      end
   end
endmodule

//--- eeprom_cfg_field_loader.sv
/*
 Loads configuration words 54h..62h from the configuration memory into per-port
 configuration fields and serves them read-only over AXI4-Lite.
 Assumes a word reader on aclk answers ee_req with ee_ack and ee_rdata, and that
 ee_present comes from a pin.
*/
// Function
// - Bit 0 of word 54h becomes port 2's soft-reset flag, bit 3 of dword 44h, defaulting to FFh.
// - Bits 3:1 of word 54h become port 2's auxiliary current, bits 24:22 of dword 40h.
// - Bits 4 and 5 of a power word are unused; D1/D2 support bits 25 and 26 always read as 1.
// - Bits 7:6 of a power word load wake support bits 29:28 of dword 40h.
// - Bits 15:8 of word 54h become port 2's read-only power data, bits 31:24 of dword 44h, default 00h.
// - Word 56h fills port 3's power fields with the same mapping, defaulting to FFh.
// - Bit 1 of word 60h becomes port 0's connector clock bit 28 of dword D0h, default 02h.
// - Bit 2 of word 60h becomes port 0's initialization-required bit 21 of dword 40h.
// - Bit 3 of word 60h becomes port 0's low priority channel count bit 4 of dword 144h.
// - Bits 6:4 of word 60h become port 0's logical port number, bits 26:24 of dword CCh.
// - Bits 15:9 of word 60h become port 0's traffic class map, bits 7:1 of dword 154h, default FEh.
// - Bit 0 of word 62h becomes port 1's slot implemented bit 24 of dword C0h, default 12h.
// - Bits 15:1 of word 62h fill port 1's fields as word 60h does for port 0.
`timescale 1ns/1ps
`include "cfg_loader_params.svh"
module eeprom_cfg_field_loader
   import cfg_loader_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ee_present,
   output logic ee_req,
   output logic [7:0] ee_addr,
   input wire logic ee_ack,
   input wire logic [15:0] ee_rdata,
   output logic load_done,
   output logic [15:0] pm_cfg_word_p2,
   output logic [15:0] pm_cfg_word_p3,
   output logic [63:0] link_layer_ctrl_word,
   output logic [15:0] port_cfg_word_p0,
   output logic [15:0] port_cfg_word_p1,
   input wire logic [15:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [15:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready
);
   load_state_e state_r, state_nxt;
   logic [2:0] idx_r, idx_nxt;
   logic [1:0] settle_r, settle_nxt;
   logic [7:0] ee_addr_r, ee_addr_nxt;
   logic ee_req_r, ee_req_nxt, used_mem_r, used_mem_nxt;
   logic pres1_r, pres2_r, pres3_r, present_r, present_nxt;
   logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt, reload_bit_r, reload_bit_nxt;
   logic awready_r, awready_nxt, wready_r, wready_nxt, bvalid_r, bvalid_nxt;
   logic arready_r, arready_nxt, rvalid_r, rvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   logic [15:0] awaddr_r, awaddr_nxt, rd_addr_r, rd_addr_nxt;
   logic [31:0] rdata_r, rdata_nxt, rd_word;
   logic [15:0] slot_w [8];
   logic fetch_ack;

   function automatic logic map_ok(input logic [15:0] a);
      logic [1:0] p;
      p = a[13:12];
      map_ok = 1'b0;
      if (a == `CTRL_ADDR || a == `STAT_ADDR)
      begin
         map_ok = 1'b1;
      end
      else if (a[15:14] == 2'b00)
      begin
         case (a[11:0])
            `OFF_LLCTRL, `OFF_PMCAP: map_ok = 1'b1;
            `OFF_PMDATA: map_ok = p[1];
            `OFF_SLOTCLK, `OFF_VCCNT, `OFF_PORTNUM, `OFF_TCMAP: map_ok = !p[1];
            `OFF_SLOTCAP: map_ok = (p == 2'd1);
            default: map_ok = 1'b0;
         endcase
      end
   endfunction

   assign fetch_ack = (state_r == ST_FETCH) && ee_ack;
   // Word 0/1 power words, 2..5 link words, 6/7 port 0/1 words
   for (genvar i = 0; i < 8; i++)
   begin : g_slot
      localparam logic [15:0] DEF = (i < 2) ? `DEF_PM_WORD : (i < 6) ? `DEF_LL_WORD :
                                    (i == 6) ? `DEF_P0_WORD : `DEF_P1_WORD;
      cfg_word_slot #(.RESET_VAL(DEF)) u_slot (
         .aclk(aclk),
         .aresetn(aresetn),
         .load(fetch_ack && (idx_r == 3'(i))),
         .load_data(ee_rdata),
         .word(slot_w[i])
      );
   end

   // Read view of the configuration dwords
   always_comb
   begin
      logic [1:0] p;
      logic [15:0] pm;
      logic [15:0] mw;
      p = araddr[13:12];
      pm = p[0] ? slot_w[1] : slot_w[0];
      mw = p[0] ? slot_w[7] : slot_w[6];
      rd_word = 32'h0000_0000;
      if (araddr == `STAT_ADDR)
      begin
         rd_word[3:0] = {used_mem_r, present_r, state_r == ST_FETCH, state_r == ST_DONE};
      end
      else if (araddr[15:14] == 2'b00)
      begin
         case (araddr[11:0])
            `OFF_PMCAP:
            begin
               if (p[1])
               begin
                  rd_word[`AUX_LSB +: 3] = pm[3:1];
                  rd_word[`D1_BIT] = 1'b1;
                  rd_word[`D2_BIT] = 1'b1;
                  rd_word[`PME_LSB +: 2] = pm[7:6];
               end
               else
               begin
                  rd_word[`DSI_BIT] = mw[2];
               end
            end
            `OFF_PMDATA:
            begin
               if (p[1])
               begin
                  rd_word[`NSR_BIT] = pm[0];
                  rd_word[`PMDATA_LSB +: 8] = pm[15:8];
               end
            end
            `OFF_SLOTCAP: rd_word[`SLOTI_BIT] = (p == 2'd1) && mw[0];
            `OFF_SLOTCLK: rd_word[`CLKCFG_BIT] = !p[1] && mw[1];
            `OFF_VCCNT: rd_word[`LOW_PRIORITY_VC_COUNT_BIT] = !p[1] && mw[3];
            `OFF_PORTNUM: rd_word[`PNUM_LSB +: 3] = p[1] ? 3'd0 : mw[6:4];
            `OFF_TCMAP: rd_word[`TCMAP_LSB +: 7] = p[1] ? 7'd0 : mw[15:9];
            `OFF_LLCTRL: rd_word[15:0] = slot_w[3'(p) + 3'd2];
            default: rd_word = 32'h0000_0000;
         endcase
      end
   end

   always_comb
   begin
      state_nxt = state_r;
      idx_nxt = idx_r;
      settle_nxt = settle_r;
      ee_addr_nxt = ee_addr_r;
      ee_req_nxt = ee_req_r;
      used_mem_nxt = used_mem_r;
      present_nxt = (pres2_r == pres3_r) ? pres3_r : present_r;
      aw_got_nxt = aw_got_r | (awvalid && awready_r);
      w_got_nxt = w_got_r | (wvalid && wready_r);
      awaddr_nxt = (awvalid && awready_r) ? awaddr : awaddr_r;
      reload_bit_nxt = (wvalid && wready_r) ? (wdata[0] && wstrb[0]) : reload_bit_r;
      bvalid_nxt = bvalid_r && !bready;
      bresp_nxt = bresp_r;
      rvalid_nxt = rvalid_r && !rready;
      rresp_nxt = rresp_r;
      rdata_nxt = rdata_r;
      rd_addr_nxt = rd_addr_r;
      case (state_r)
         ST_WAIT:
         begin
            settle_nxt = settle_r + 2'd1;
            if (settle_r == `SETTLE_CYCLES)
            begin
               settle_nxt = 2'd0;
               idx_nxt = 3'd0;
               used_mem_nxt = present_nxt;
               state_nxt = present_nxt ? ST_FETCH : ST_DONE;
               ee_req_nxt = present_nxt;
               ee_addr_nxt = `WORD_FIRST;
            end
         end
         ST_FETCH:
         begin
            if (ee_ack)
            begin
               idx_nxt = idx_r + 3'd1;
               ee_addr_nxt = ee_addr_r + `WORD_STEP;
               if (idx_r == `WORD_LAST_IDX)
               begin
                  ee_req_nxt = 1'b0;
                  state_nxt = ST_DONE;
               end
            end
         end
         ST_DONE: state_nxt = ST_DONE;
         default: state_nxt = ST_WAIT;
      endcase
      // Writes never touch loaded fields; only the control word acts
      if (aw_got_r && w_got_r && !bvalid_r)
      begin
         aw_got_nxt = 1'b0;
         w_got_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt = map_ok(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
         if (awaddr_r == `CTRL_ADDR && reload_bit_r && state_r == ST_DONE)
         begin
            state_nxt = ST_WAIT;
         end
      end
      if (arvalid && arready_r)
      begin
         rvalid_nxt = 1'b1;
         rdata_nxt = rd_word;
         rd_addr_nxt = araddr;
         rresp_nxt = map_ok(araddr) ? RESP_OKAY : RESP_SLVERR;
      end
      awready_nxt = !aw_got_nxt && !bvalid_nxt;
      wready_nxt = !w_got_nxt && !bvalid_nxt;
      arready_nxt = (state_nxt == ST_DONE) && !rvalid_nxt;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_r <= ST_WAIT;
         idx_r <= 3'd0;
         settle_r <= 2'd0;
         ee_addr_r <= 8'h00;
         ee_req_r <= 1'b0;
         used_mem_r <= 1'b0;
         pres1_r <= 1'b0;
         pres2_r <= 1'b0;
         pres3_r <= 1'b0;
         present_r <= 1'b0;
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         awaddr_r <= 16'h0000;
         reload_bit_r <= 1'b0;
         awready_r <= 1'b0;
         wready_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= 2'b00;
         arready_r <= 1'b0;
         rvalid_r <= 1'b0;
         rresp_r <= 2'b00;
         rdata_r <= 32'h0000_0000;
         rd_addr_r <= 16'h0000;
      end
      else
      begin
         state_r <= state_nxt;
         idx_r <= idx_nxt;
         settle_r <= settle_nxt;
         ee_addr_r <= ee_addr_nxt;
         ee_req_r <= ee_req_nxt;
         used_mem_r <= used_mem_nxt;
         pres1_r <= ee_present;
         pres2_r <= pres1_r;
         pres3_r <= pres2_r;
         present_r <= present_nxt;
         aw_got_r <= aw_got_nxt;
         w_got_r <= w_got_nxt;
         awaddr_r <= awaddr_nxt;
         reload_bit_r <= reload_bit_nxt;
         awready_r <= awready_nxt;
         wready_r <= wready_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         arready_r <= arready_nxt;
         rvalid_r <= rvalid_nxt;
         rresp_r <= rresp_nxt;
         rdata_r <= rdata_nxt;
         rd_addr_r <= rd_addr_nxt;
      end
   end

   assign ee_req = ee_req_r;
   assign ee_addr = ee_addr_r;
   assign load_done = state_r[2];
   assign pm_cfg_word_p2 = slot_w[0];
   assign pm_cfg_word_p3 = slot_w[1];
   assign link_layer_ctrl_word = {slot_w[5], slot_w[4], slot_w[3], slot_w[2]};
   assign port_cfg_word_p0 = slot_w[6];
   assign port_cfg_word_p1 = slot_w[7];
   assign awready = awready_r;
   assign wready = wready_r;
   assign bvalid = bvalid_r;
   assign bresp = bresp_r;
   assign arready = arready_r;
   assign rvalid = rvalid_r;
   assign rresp = rresp_r;
   assign rdata = rdata_r;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   p2_pmdata_a: assert property ((rvalid_r && rd_addr_r == 16'h2044) |->
      (rdata_r[3] == slot_w[0][0] && rdata_r[31:24] == slot_w[0][15:8]))
      else $error("port 2 power data read mismatch");
   p2_pmcap_a: assert property ((rvalid_r && rd_addr_r == 16'h2040) |->
      (rdata_r[24:22] == slot_w[0][3:1] && rdata_r[29:28] == slot_w[0][7:6]))
      else $error("port 2 power capability read mismatch");
   d1d2_ones_a: assert property ((rvalid_r && rd_addr_r == 16'h3040) |-> rdata_r[26:25] == 2'b11)
      else $error("D1 D2 support not read as one");
   p3_pmdata_a: assert property ((rvalid_r && rd_addr_r == 16'h3044) |-> rdata_r[3] == slot_w[1][0])
      else $error("port 3 soft reset flag mismatch");
   ll_load_a: assert property ((fetch_ack && idx_r == 3'd3) |=> slot_w[3] == $past(ee_rdata))
      else $error("port 1 link control word not loaded");
   p0_fields_a: assert property ((rvalid_r && rd_addr_r == 16'h0154) |-> rdata_r[7:1] == slot_w[6][15:9])
      else $error("port 0 traffic class map mismatch");
   p0_clk_a: assert property ((rvalid_r && rd_addr_r == 16'h00D0) |-> rdata_r[28] == slot_w[6][1])
      else $error("port 0 clock bit mismatch");
   p1_slot_a: assert property ((rvalid_r && rd_addr_r == 16'h10C0) |-> rdata_r[24] == slot_w[7][0])
      else $error("port 1 slot bit mismatch");
   read_gate_a: assert property ((state_r != ST_DONE) |-> !arready_r && !rvalid_r)
      else $error("read accepted before load finished");
   field_hold_a: assert property ((state_r == ST_DONE && $past(state_r == ST_DONE)) |->
      ($stable(slot_w[0]) && $stable(slot_w[3]) && $stable(slot_w[6]) && $stable(slot_w[7])))
      else $error("loaded field changed after load");
   absent_def_a: assert property ((state_r == ST_DONE && !used_mem_r && !$past(used_mem_r)) |->
      (slot_w[0] == `DEF_PM_WORD && slot_w[6] == `DEF_P0_WORD && slot_w[2] == `DEF_LL_WORD))
      else $error("defaults lost without memory");

   load_mem_c: cover property (state_r == ST_FETCH ##[1:100] state_r == ST_DONE);
   load_none_c: cover property (state_r == ST_WAIT && !present_r ##1 state_r == ST_DONE);
   bad_write_c: cover property (bvalid_r && bresp_r == RESP_SLVERR);
   read_wait_c: cover property (arvalid && !arready_r ##1 arvalid && arready_r);
endmodule

//--- eeprom_cfg_field_loader_bench.sv
/*
 Self-checking bench of the configuration word loader: AXI4-Lite tasks and field checks.
 Assumes the memory model answers the word link and the loader serves fields read-only.
*/
`timescale 1ns/1ps
`include "cfg_loader_params.svh"
`define CHK(a, e) begin n_compared = n_compared + 1; if ((a) !== (e)) begin n_fail = n_fail + 1; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module eeprom_cfg_field_loader_bench;
   import cfg_loader_pkg::*;
   logic aclk, aresetn, ee_present, ee_req, ee_ack, load_done;
   logic [7:0] ee_addr;
   logic [15:0] ee_rdata, pm_cfg_word_p2, pm_cfg_word_p3, port_cfg_word_p0, port_cfg_word_p1;
   logic [63:0] link_layer_ctrl_word;
   logic [15:0] awaddr, araddr;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [31:0] wdata, rdata, rd_data;
   logic [3:0] wstrb, ack_delay;
   logic [1:0] bresp, rresp, rd_resp, wr_resp;
   logic flip_data;
   logic [15:0] exp_w [8];
   logic [15:0] w;
   int n_fail, n_compared;

   eeprom_cfg_field_loader u_dut (.aclk(aclk), .aresetn(aresetn), .ee_present(ee_present), .ee_req(ee_req),
      .ee_addr(ee_addr), .ee_ack(ee_ack), .ee_rdata(ee_rdata), .load_done(load_done),
      .pm_cfg_word_p2(pm_cfg_word_p2), .pm_cfg_word_p3(pm_cfg_word_p3),
      .link_layer_ctrl_word(link_layer_ctrl_word), .port_cfg_word_p0(port_cfg_word_p0),
      .port_cfg_word_p1(port_cfg_word_p1), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready));

   ee_word_model u_mem (.aclk(aclk), .aresetn(aresetn), .ee_req(ee_req), .ee_addr(ee_addr),
      .ack_delay(ack_delay), .flip_data(flip_data), .ee_ack(ee_ack), .ee_rdata(ee_rdata));

   initial
   begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end

   task report_and_stop;
      $display("compared %0d, mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task timed_out;
      n_fail = n_fail + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      report_and_stop();
   endtask

   task axi_write(input logic [15:0] a, input logic [31:0] d);
      int i;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (i = 0; i < 500; i++)
      begin
         @(posedge aclk);
         if (awvalid && awready)
            awvalid <= 1'b0;
         if (wvalid && wready)
            wvalid <= 1'b0;
         if (bvalid)
            break;
      end
      if (i == 500)
         timed_out();
      wr_resp = bresp;
      bready <= 1'b0;
   endtask

   task axi_read(input logic [15:0] a);
      int i;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (i = 0; i < 500; i++)
      begin
         @(posedge aclk);
         if (arvalid && arready)
            arvalid <= 1'b0;
         if (rvalid)
            break;
      end
      if (i == 500)
         timed_out();
      rd_data = rdata;
      rd_resp = rresp;
      rready <= 1'b0;
   endtask

   task wait_load;
      int i;
      for (i = 0; i < 500 && load_done !== 1'b1; i++)
         @(posedge aclk);
      if (i == 500)
         timed_out();
   endtask

   task do_reset;
      aresetn <= 1'b0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
   endtask

   task set_words(input logic f);
      for (int i = 0; i < 8; i++)
      begin
         w = {8'h54 + 8'(2 * i) ^ 8'h0F, ~(8'h54 + 8'(2 * i)) ^ 8'h22};
         exp_w[i] = f ? ~w : w;
      end
   endtask

   task check_all;
      `CHK(pm_cfg_word_p2, exp_w[0])
      `CHK(pm_cfg_word_p3, exp_w[1])
      `CHK(port_cfg_word_p0, exp_w[6])
      `CHK(port_cfg_word_p1, exp_w[7])
      for (int p = 0; p < 4; p++)
      begin
         axi_read({4'(p), 12'h340});
         `CHK(rd_data, {16'h0000, exp_w[2 + p]})
         `CHK(link_layer_ctrl_word[16 * p +: 16], exp_w[2 + p])
      end
      for (int p = 2; p < 4; p++)
      begin
         w = exp_w[p - 2];
         axi_read({4'(p), 12'h044});
         `CHK(rd_data, {w[15:8], 20'h0_0000, w[0], 3'b000})
         axi_read({4'(p), 12'h040});
         `CHK(rd_data, {2'b00, w[7:6], 1'b0, 2'b11, w[3:1], 22'h00_0000})
      end
      for (int p = 0; p < 2; p++)
      begin
         w = exp_w[6 + p];
         axi_read({4'(p), 12'h040});
         `CHK(rd_data, {10'h000, w[2], 21'h00_0000})
         axi_read({4'(p), 12'h0D0});
         `CHK(rd_data, {3'b000, w[1], 28'h000_0000})
         axi_read({4'(p), 12'h144});
         `CHK(rd_data, {27'h000_0000, w[3], 4'h0})
         axi_read({4'(p), 12'h0CC});
         `CHK(rd_data, {5'h00, w[6:4], 24'h00_0000})
         axi_read({4'(p), 12'h154});
         `CHK(rd_data, {24'h00_0000, w[15:9], 1'b0})
      end
      axi_read(16'h10C0);
      `CHK(rd_data, {7'h00, exp_w[7][0], 24'h00_0000})
   endtask

   initial
   begin
      n_fail = 0;
      n_compared = 0;
      aresetn = 1'b0;
      ee_present = 1'b0;
      ack_delay = 4'h0;
      flip_data = 1'b0;
      awaddr = 16'h0000;
      araddr = 16'h0000;
      wdata = 32'h0000_0000;
      wstrb = 4'h0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'b00000;
      do_reset();
      wait_load();
      exp_w = '{`DEF_PM_WORD, `DEF_PM_WORD, `DEF_LL_WORD, `DEF_LL_WORD, `DEF_LL_WORD, `DEF_LL_WORD,
         `DEF_P0_WORD, `DEF_P1_WORD};
      axi_write(16'h2044, 32'hFFFF_FFFF);
      `CHK(wr_resp, RESP_OKAY)
      axi_write(16'h0154, 32'h0000_0000);
      `CHK(wr_resp, RESP_OKAY)
      check_all();
      axi_read(`STAT_ADDR);
      `CHK(rd_data, 32'h0000_0001)
      axi_read(16'h0008);
      `CHK(rd_resp, RESP_SLVERR)
      `CHK(rd_data, 32'h0000_0000)
      axi_write(16'h0008, 32'h0000_0001);
      `CHK(wr_resp, RESP_SLVERR)
      ee_present <= 1'b1;
      do_reset();
      set_words(1'b0);
      axi_read(16'h3340);
      `CHK(load_done, 1'b1)
      `CHK(rd_data, {16'h0000, exp_w[5]})
      check_all();
      axi_read(`STAT_ADDR);
      `CHK(rd_data, 32'h0000_000D)
      flip_data <= 1'b1;
      ack_delay <= 4'h3;
      axi_write(`CTRL_ADDR, 32'h0000_0001);
      for (int i = 0; i < 50 && ee_req !== 1'b1; i++)
         @(posedge aclk);
      `CHK(ee_req, 1'b1)
      `CHK(ee_addr, 8'h54)
      wait_load();
      set_words(1'b1);
      check_all();
      axi_read(`STAT_ADDR);
      `CHK(rd_data, 32'h0000_000D)
      report_and_stop();
   end
endmodule
